// ==== rtl/mprc_reset_ctrl.sv ====
/*
 * MAC/PHY reset control: system, transmit-only, receive-only and PHY
 * soft reset, with the main control and primary PHY control registers.
 * Assumes an SPI decoder outside drives the register port and the
 * system reset command pulse, and that rst is the power-on reset.
 */
// Functional notes
// R1: Power-on reset loads every register default; packet buffer left undefined.
// R2: System reset holds while the external reset pin stays low.
// R3: Low pulses on the reset pin up to the glitch time are ignored.
// R4: The SPI system reset command performs a full system reset.
// R5: No internal reset ever drives the reset pin; it is input only.
// R6: System reset restores register defaults and keeps buffer contents.
// R7: Host waits 50 us after system reset before any PHY access.
// R8: System reset also applies the transmit-only and receive-only resets.
// R9: Setting transmit reset mid-transmission aborts it and clears request.
// R10: Transmit reset touches only the transmit logic.
// R11: Host clears transmit reset to resume transmitting.
// R12: Setting receive reset clears receive enable and aborts any frame.
// R13: Receive reset touches only receive logic; host clears it to resume.
// R14: PHY soft reset returns all PHY control bits to defaults.
// R15: PHY soft reset bit reads one until the delay ends, then self-clears.
// R16: Host polls PHY soft reset bit and waits until it reads zero.
// R17: Loopback returns transmit data to receive and disables twisted pair.
// R18: Power-down bit shuts the PHY down; zero means normal operation.
// R19: Duplex bit selects full or half duplex; reset value from LED strap.
// R20: Reserved bits written zero by host; unimplemented bits read zero.
// R21: Reset pin release is synchronised before internal logic leaves reset.
`timescale 1ns/100ps
`default_nettype none

module mprc_reset_ctrl
    import mprc_pkg::*;
#(
    parameter int SETTLE_CYC = PHY_SETTLE_CYC,
    parameter int PHY_SOFT_RESET_BIT_CYC   = PHY_RST_CYC,
    parameter int CMD_CYC    = SYS_CMD_CYC,
    parameter int FILT_CYC   = RST_GLITCH_CYC
) (
    input  wire logic        sys_clk,
    input  wire logic        rst,
    input  wire logic        reset_pin_n,
    input  wire logic        second_led_pin,
    input  wire logic        sys_reset_cmd,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    input  wire logic        reg_sel,
    input  wire logic [15:0] reg_wdata,
    input  wire logic        tx_busy,
    input  wire logic        tx_done,
    input  wire logic        rx_busy,
    output var  logic [15:0] reg_rdata,
    output var  logic [7:0]  main_ctrl,
    output var  logic        sys_reset_active,
    output var  logic        tx_reset,
    output var  logic        rx_reset,
    output var  logic        tx_abort,
    output var  logic        rx_abort,
    output var  logic        phy_reset,
    output var  logic        phy_loopback,
    output var  logic        phy_power_down,
    output var  logic        phy_full_duplex,
    output var  logic        tp_disable,
    output var  logic        phy_access_ok
);

    typedef struct packed {
        mprc_sysrst_t     sr;
        logic             sr_act;
        logic [CNT_W-1:0] sr_cnt;
        logic [CNT_W-1:0] settle_cnt;
        logic             settle_ok;
        logic [2:0]       led_sync;
        logic [1:0]       strap_cnt;
        logic             strap_done;
        logic             strap_val;
        logic [7:0]       mc;
        logic [15:0]      pc;
        logic             phy_soft_reset_bit;
        logic [CNT_W-1:0] phy_soft_reset_bit_cnt;
        logic [15:0]      rdata;
        logic             tx_rst;
        logic             rx_rst;
        logic             tx_abt;
        logic             rx_abt;
        logic             phy_rst;
        logic             tp_dis;
    } mprc_state_t;

    mprc_state_t s_reg;
    mprc_state_t s_next;
    logic        pin_low;

    // Only the pin input is observed; no output exists toward the pin.
    mprc_rst_filter #(
        .FILT_CYC (FILT_CYC)
    ) u_filter (
        .sys_clk  (sys_clk),
        .rst      (rst),
        .pin_n    (reset_pin_n), // R5
        .pin_low  (pin_low)
    );

    // PHY control defaults, with duplex taken from the captured strap.
    function automatic logic [15:0] phy_default(input logic strap);
        logic [15:0] v;
        v = PHY_CTRL_RST;
        v[PC_DUPLEX] = strap; // R19
        return v;
    endfunction

    // Register port decode, shared by the write and read paths.
    function automatic logic is_main_sel(input logic sel);
        return sel == REG_SEL_MAIN_CTRL;
    endfunction

    // PHY control readback: soft reset flag live, unimplemented bits zero.
    function automatic logic [15:0] phy_readback(input logic [15:0] pc,
                                                 input logic        busy);
        logic [15:0] v;
        v = pc & PHY_CTRL_WMASK; // R20
        v[PC_SOFT_RESET] = busy; // R15
        return v;
    endfunction

    // True on the last cycle of a count of n cycles started at zero.
    function automatic logic cnt_last(input logic [CNT_W-1:0] c,
                                      input int               n);
        return c == CNT_W'(n - 1);
    endfunction

    always_comb begin
        logic [7:0]  mc_w;
        logic        in_rst;
        mc_w   = '0;
        in_rst = 1'b0;
        s_next = s_reg;
        // Abort pulses last one cycle; the engines act on the pulse alone.
        s_next.tx_abt = 1'b0;
        s_next.rx_abt = 1'b0;

        // Strap sampling starts only once the synchroniser has filled.
        s_next.led_sync = {s_reg.led_sync[1:0], second_led_pin};
        if (!s_reg.strap_done) begin
            if (s_reg.strap_cnt != 2'(STRAP_WAIT_CYC)) begin
                s_next.strap_cnt = s_reg.strap_cnt + 2'h1;
            end else if (s_reg.led_sync[1] == s_reg.led_sync[2]) begin
                s_next.strap_done = 1'b1;
                s_next.strap_val  = s_reg.led_sync[2];
                s_next.pc         = phy_default(s_reg.led_sync[2]); // R19
            end
        end

        case (s_reg.sr)
            SR_RUN: begin
                if (pin_low) begin
                    s_next.sr = SR_PIN; // R2
                end else if (sys_reset_cmd) begin
                    s_next.sr     = SR_CMD; // R4
                    s_next.sr_cnt = '0;
                end
            end
            SR_PIN: begin
                if (!pin_low) begin
                    s_next.sr = SR_RUN; // R2
                end
            end
            SR_CMD: begin
                s_next.sr_cnt = s_reg.sr_cnt + CNT_W'(1);
                // A pin reset arriving now takes over and lasts with the pin.
                if (pin_low) begin
                    s_next.sr = SR_PIN; // R2
                end else if (cnt_last(s_reg.sr_cnt, CMD_CYC)) begin
                    s_next.sr = SR_RUN;
                end
            end
            default: begin
                s_next.sr = SR_RUN;
            end
        endcase
        // Outputs follow the next state, so resets show the cycle they start.
        in_rst = (s_next.sr != SR_RUN);

        if (in_rst) begin
            // Packet buffer is outside this block and is never touched.
            // Host writes are dropped here, since every register is held.
            s_next.mc         = MAIN_CTRL_RST; // R6
            // The strap captured this cycle is used, so that a reset
            // overlapping the capture still leaves the strapped duplex.
            s_next.pc         = phy_default(s_next.strap_val); // R6
            s_next.phy_soft_reset_bit       = 1'b0;
            s_next.phy_soft_reset_bit_cnt   = '0;
            s_next.settle_cnt = '0;
            s_next.settle_ok  = 1'b0;
        end else begin
            // Gives the host a visible end to the PHY settling window.
            if (!s_reg.settle_ok) begin
                s_next.settle_cnt = s_reg.settle_cnt + CNT_W'(1);
                if (cnt_last(s_reg.settle_cnt, SETTLE_CYC)) begin
                    s_next.settle_ok = 1'b1; // R7
                end
            end

            // A host write in the same cycle as the end of a frame wins below.
            if (tx_done) begin
                s_next.mc[MC_TX_REQUEST] = 1'b0;
            end

            if (reg_wr && is_main_sel(reg_sel)) begin
                mc_w = reg_wdata[7:0];
                if (mc_w[MC_TX_RESET] && tx_busy) begin
                    mc_w[MC_TX_REQUEST] = 1'b0; // R9
                    s_next.tx_abt       = 1'b1; // R9
                end
                if (mc_w[MC_TX_RESET]) begin
                    mc_w[MC_TX_REQUEST] = 1'b0; // R10
                end
                // Receive enable is forced low on every receive reset write.
                if (mc_w[MC_RX_RESET]) begin
                    mc_w[MC_RX_ENABLE] = 1'b0; // R12
                    s_next.rx_abt      = rx_busy; // R12
                end
                // Other fields are stored as written either way.
                s_next.mc = mc_w; // R11 R13
            end

            // A write arriving while the soft reset runs is dropped, not kept.
            if (s_reg.phy_soft_reset_bit) begin
                s_next.phy_soft_reset_bit_cnt = s_reg.phy_soft_reset_bit_cnt + CNT_W'(1);
                if (cnt_last(s_reg.phy_soft_reset_bit_cnt, PHY_SOFT_RESET_BIT_CYC)) begin
                    s_next.phy_soft_reset_bit = 1'b0; // R15
                end
            end else if (reg_wr && reg_sel == REG_SEL_PHY_CTRL) begin
                if (reg_wdata[PC_SOFT_RESET]) begin
                    s_next.phy_soft_reset_bit     = 1'b1; // R15
                    s_next.phy_soft_reset_bit_cnt = '0;
                    s_next.pc       = phy_default(s_reg.strap_val); // R14
                end else begin
                    s_next.pc = reg_wdata & PHY_CTRL_WMASK; // R20
                end
            end
        end

        // Reads return the state as it stood when the read was taken.
        if (reg_rd) begin
            if (is_main_sel(reg_sel)) begin
                s_next.rdata = {8'h00, s_reg.mc};
            end else begin
                s_next.rdata = phy_readback(s_reg.pc, s_reg.phy_soft_reset_bit); // R15 R20
            end
        end

        s_next.tx_rst  = in_rst | s_next.mc[MC_TX_RESET]; // R8 R10
        s_next.rx_rst  = in_rst | s_next.mc[MC_RX_RESET]; // R8 R13
        s_next.sr_act  = in_rst; // R2 R4
        s_next.phy_rst = in_rst | s_next.phy_soft_reset_bit;
        // A PHY held in reset never drives the pair, whatever its bits say.
        s_next.tp_dis  = s_next.pc[PC_LOOPBACK] // R17
                       | s_next.pc[PC_POWER_DOWN] // R18
                       | s_next.phy_rst;
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            // Power-on defaults; buffer memory content is not ours.
            s_reg <= '{sr:         SR_RUN, // R1
                       sr_act:     1'b0,
                       sr_cnt:     '0,
                       settle_cnt: '0,
                       settle_ok:  1'b0,
                       led_sync:   3'h0,
                       strap_cnt:  2'h0,
                       strap_done: 1'b0,
                       strap_val:  1'b0,
                       mc:         MAIN_CTRL_RST,
                       pc:         PHY_CTRL_RST,
                       phy_soft_reset_bit:       1'b0,
                       phy_soft_reset_bit_cnt:   '0,
                       rdata:      16'h0000,
                       tx_rst:     1'b1,
                       rx_rst:     1'b1,
                       tx_abt:     1'b0,
                       rx_abt:     1'b0,
                       phy_rst:    1'b1,
                       tp_dis:     1'b1};
        end else begin
            s_reg <= s_next;
        end
    end

    assign reg_rdata        = s_reg.rdata;
    assign main_ctrl        = s_reg.mc;
    // A registered copy keeps this output straight from a flop.
    assign sys_reset_active = s_reg.sr_act;
    assign tx_reset         = s_reg.tx_rst;
    assign rx_reset         = s_reg.rx_rst;
    assign tx_abort         = s_reg.tx_abt;
    assign rx_abort         = s_reg.rx_abt;
    assign phy_reset        = s_reg.phy_rst;
    assign phy_loopback     = s_reg.pc[PC_LOOPBACK]; // R17
    assign phy_power_down   = s_reg.pc[PC_POWER_DOWN]; // R18
    assign phy_full_duplex  = s_reg.pc[PC_DUPLEX]; // R19
    assign tp_disable       = s_reg.tp_dis;
    assign phy_access_ok    = s_reg.settle_ok;

endmodule // mprc_reset_ctrl

`default_nettype wire

// ==== rtl/mprc_pkg.sv ====
/*
 * Constants and types shared by the MAC/PHY reset control block.
 * Assumes a single 125 MHz system clock and a register port driven
 * by an SPI command decoder that lives outside this block.
 */
`default_nettype none

package mprc_pkg;

    // Clock rate and timing figures.
    localparam int CLK_MHZ        = 125;
    localparam int PHY_SETTLE_US  = 50;
    localparam int PHY_SETTLE_CYC = PHY_SETTLE_US * CLK_MHZ;
    // Longest reset-pin glitch that is ignored; rounded up to cycles.
    localparam int RST_GLITCH_NS  = 200;
    localparam int RST_GLITCH_CYC = (RST_GLITCH_NS * CLK_MHZ + 999) / 1000;
    localparam int PHY_RST_CYC    = 256;
    localparam int SYS_CMD_CYC    = 16;
    localparam int STRAP_WAIT_CYC = 3;
    localparam int CNT_W          = 16;

    // Register selection on the register port.
    localparam logic REG_SEL_MAIN_CTRL = 1'b0;
    localparam logic REG_SEL_PHY_CTRL  = 1'b1;

    // Ethernet main control field positions.
    localparam int MC_TX_RESET   = 7;
    localparam int MC_RX_RESET   = 6;
    localparam int MC_TX_REQUEST = 3;
    localparam int MC_RX_ENABLE  = 2;
    localparam logic [7:0] MAIN_CTRL_RST = 8'h00;

    // Primary PHY control field positions.
    localparam int PC_SOFT_RESET = 15;
    localparam int PC_LOOPBACK   = 14;
    localparam int PC_POWER_DOWN = 11;
    localparam int PC_DUPLEX     = 8;
    localparam logic [15:0] PHY_CTRL_RST   = 16'h0000;
    // Stored bits: loopback, power-down, reserved 10, duplex, reserved 7.
    localparam logic [15:0] PHY_CTRL_WMASK = 16'h4D80;

    typedef enum logic [2:0] {
        SR_RUN  = 3'b001,
        SR_PIN  = 3'b010,
        SR_CMD  = 3'b100
    } mprc_sysrst_t;

endpackage

`default_nettype wire

// ==== rtl/mprc_rst_filter.sv ====
/*
 * Reset pin conditioner: three-flop synchroniser and glitch filter.
 * Assumes the pin is asynchronous to sys_clk and idles high.
 */
`timescale 1ns/100ps
`default_nettype none

module mprc_rst_filter
    import mprc_pkg::*;
#(
    parameter int FILT_CYC = RST_GLITCH_CYC
) (
    input  wire logic sys_clk,
    input  wire logic rst,
    input  wire logic pin_n,
    output var  logic pin_low
);

    typedef struct packed {
        logic [2:0]       sync;
        logic [CNT_W-1:0] cnt;
        logic             low;
    } mprc_filt_t;

    mprc_filt_t s_reg;
    mprc_filt_t s_next;

    always_comb begin
        s_next = s_reg;
        // The first stage feeds only the second stage.
        s_next.sync = {s_reg.sync[1:0], pin_n};
        if (s_reg.sync[1] == s_reg.sync[2]) begin
            if (!s_reg.sync[2]) begin
                // Low must outlast the glitch window to count.
                if (s_reg.cnt > CNT_W'(FILT_CYC)) begin // R3
                    s_next.low = 1'b1;
                end else begin
                    s_next.cnt = s_reg.cnt + CNT_W'(1);
                end
            end else begin
                // Release is seen only after synchronisation.
                s_next.cnt = '0; // R21
                s_next.low = 1'b0;
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            s_reg <= '{sync: 3'h7, cnt: '0, low: 1'b0};
        end else begin
            s_reg <= s_next;
        end
    end

    assign pin_low = s_reg.low;

endmodule // mprc_rst_filter

`default_nettype wire

// ==== verif/mprc_reset_ctrl_assertions.sv ====
/*
 * Checker for the MAC/PHY reset control block, bound to its top.
 * Assumes the bench runs CMD_CYC 4, PHY_SOFT_RESET_BIT_CYC 8 and FILT_CYC 4.
 */
`timescale 1ns/100ps
`default_nettype none

module mprc_reset_ctrl_assertions
    import mprc_pkg::*;
(
    input wire logic        sys_clk,
    input wire logic        rst,
    input wire logic        reset_pin_n,
    input wire logic        sys_reset_cmd,
    input wire logic        reg_wr,
    input wire logic        reg_rd,
    input wire logic        reg_sel,
    input wire logic [15:0] reg_wdata,
    input wire logic        tx_busy,
    input wire logic [15:0] reg_rdata,
    input wire logic [7:0]  main_ctrl,
    input wire logic        sys_reset_active,
    input wire logic        tx_reset,
    input wire logic        rx_reset,
    input wire logic        tx_abort,
    input wire logic        phy_reset,
    input wire logic        phy_loopback,
    input wire logic        phy_power_down,
    input wire logic        phy_full_duplex,
    input wire logic        tp_disable,
    input wire logic        phy_access_ok
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);
    sequence s_main_wr;
        reg_wr && !reg_sel && !sys_reset_active;
    endsequence
    sequence s_phy_wr;
        reg_wr && reg_sel && !phy_reset && !sys_reset_active;
    endsequence
    property p_tx_rst;
        s_main_wr ##0 (reg_wdata[7] && tx_busy) |=> tx_abort && !main_ctrl[3];
    endproperty
    property p_rx_rst;
        s_main_wr ##0 reg_wdata[6] |=> !main_ctrl[2] && rx_reset;
    endproperty
    property p_cmd;
        sys_reset_cmd && !sys_reset_active && reset_pin_n
            |=> (sys_reset_active && tx_reset && rx_reset)[*4];
    endproperty
    property p_dflt;
        sys_reset_active |-> main_ctrl == MAIN_CTRL_RST && phy_reset;
    endproperty
    property p_phy_soft_reset_bit;
        s_phy_wr ##0 reg_wdata[15] |=> phy_reset[*8];
    endproperty
    property p_fields;
        s_phy_wr ##0 !reg_wdata[15] |=> phy_loopback == $past(reg_wdata[14])
            && phy_power_down == $past(reg_wdata[11])
            && phy_full_duplex == $past(reg_wdata[8]);
    endproperty
    property p_tp;
        phy_loopback || phy_power_down |-> tp_disable;
    endproperty
    property p_unimp;
        reg_rd && reg_sel |=> (reg_rdata & 16'h327F) == 16'h0000;
    endproperty
    property p_settle;
        $fell(sys_reset_active) |-> (!phy_access_ok)[*8];
    endproperty
    property p_pin;
        (!reset_pin_n)[*8] |-> ##[0:8] sys_reset_active;
    endproperty
    a_tx_rst: assert property (p_tx_rst) else $error("tx reset");
    a_rx_rst: assert property (p_rx_rst) else $error("rx reset");
    a_cmd:    assert property (p_cmd) else $error("command reset");
    a_dflt:   assert property (p_dflt) else $error("defaults");
    a_phy_soft_reset_bit:   assert property (p_phy_soft_reset_bit) else $error("phy reset");
    a_fields: assert property (p_fields) else $error("phy bits");
    a_tp:     assert property (p_tp) else $error("tp disable");
    a_unimp:  assert property (p_unimp) else $error("unimpl bits");
    a_settle: assert property (p_settle) else $error("settle");
    a_pin:    assert property (p_pin) else $error("pin reset");
endmodule // mprc_reset_ctrl_assertions

bind mprc_reset_ctrl mprc_reset_ctrl_assertions i_mprc_reset_ctrl_assertions (
    .sys_clk, .rst, .reset_pin_n, .sys_reset_cmd, .reg_wr, .reg_rd,
    .reg_sel, .reg_wdata, .tx_busy, .reg_rdata, .main_ctrl,
    .sys_reset_active, .tx_reset, .rx_reset, .tx_abort, .phy_reset,
    .phy_loopback, .phy_power_down, .phy_full_duplex, .tp_disable,
    .phy_access_ok
);

`default_nettype wire

// ==== verif/mprc_host_model.sv ====
/*
 * Host controller model driving the register port and reset command.
 * Assumes one-cycle strobes and read data one cycle after the strobe.
 */
`timescale 1ns/100ps
`default_nettype none

module mprc_host_model #(
    parameter int SETTLE = 20
) (
    input  wire logic        sys_clk,
    input  wire logic        sys_reset_active,
    input  wire logic [15:0] reg_rdata,
    output var  logic        sys_reset_cmd,
    output var  logic        reg_wr,
    output var  logic        reg_rd,
    output var  logic        reg_sel,
    output var  logic [15:0] reg_wdata
);
    int quiet = 0;
    int misses = 0;
    initial begin
        {sys_reset_cmd, reg_wr, reg_rd, reg_sel} = 4'h0;
        reg_wdata = 16'h0000;
    end
    always @(posedge sys_clk) quiet <= sys_reset_active ? 0 : quiet + 1;
    // PHY traffic waits out the settle time after a system reset.
    task automatic settle(input logic sel);
        for (int i = 0; i < 200 && sel && quiet < SETTLE; i++) begin
            @(posedge sys_clk);
        end
        if (sel && quiet < SETTLE) misses++;
    endtask
    task automatic wr(input logic sel, input logic [15:0] d);
        settle(sel);
        @(posedge sys_clk);
        #1;
        reg_sel = sel;
        reg_wdata = sel ? (d & 16'hFB7F) : d;
        reg_wr = 1'b1;
        @(posedge sys_clk);
        #1;
        reg_wr = 1'b0;
        // Released data is inverted so a stale value cannot look valid.
        reg_wdata = ~reg_wdata;
    endtask
    task automatic rd(input logic sel, output logic [15:0] q);
        settle(sel);
        @(posedge sys_clk);
        #1;
        reg_sel = sel;
        reg_rd = 1'b1;
        @(posedge sys_clk);
        #1;
        reg_rd = 1'b0;
        q = reg_rdata;
    endtask
    // No other PHY use until the soft reset bit reads zero.
    task automatic phy_wait(output int polls);
        logic [15:0] q;
        polls = 0;
        q = 16'h8000;
        while (q[15] === 1'b1 && polls < 50) begin
            rd(1'b1, q);
            polls++;
        end
    endtask
    task automatic cmd();
        @(posedge sys_clk);
        #1;
        sys_reset_cmd = 1'b1;
        @(posedge sys_clk);
        #1;
        sys_reset_cmd = 1'b0;
    endtask
endmodule // mprc_host_model

`default_nettype wire

// ==== verif/tb_mprc_reset_ctrl.sv ====
/*
 * Self-checking bench for the reset control block with a host model.
 * Assumes shortened counts: settle 20, PHY reset 8, command 4, filter 4.
 */
`timescale 1ns/100ps
`default_nettype none

module tb_mprc_reset_ctrl;
    import mprc_pkg::*;
    logic        sys_clk = 1'b0;
    logic        rst = 1'b1;
    logic        reset_pin_n = 1'b1;
    logic        second_led_pin = 1'b1;
    logic        tx_busy = 1'b0;
    logic        tx_done = 1'b0;
    logic        rx_busy = 1'b0;
    logic        sys_reset_cmd, reg_wr, reg_rd, reg_sel;
    logic [15:0] reg_wdata, reg_rdata, q;
    logic [7:0]  main_ctrl;
    logic        sys_reset_active, tx_reset, rx_reset, tx_abort, rx_abort;
    logic        phy_reset, phy_loopback, phy_power_down, phy_full_duplex;
    logic        tp_disable, phy_access_ok, seen;
    int          bad_count = 0;
    int          checks = 0;
    int          pc, d, n;
    always #4 sys_clk = ~sys_clk;
    mprc_reset_ctrl #(.SETTLE_CYC(20), .PHY_SOFT_RESET_BIT_CYC(8), .CMD_CYC(4),
        .FILT_CYC(4)) i_mprc_reset_ctrl (.*);
    mprc_host_model #(.SETTLE(20)) i_mprc_host_model (.sys_clk,
        .sys_reset_active, .reg_rdata, .sys_reset_cmd, .reg_wr, .reg_rd,
        .reg_sel, .reg_wdata);
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checks++;
        if (got !== exp) begin
            bad_count++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic end_sim();
        $display("checks=%0d bad_count=%0d", checks, bad_count);
        if (bad_count == 0 && checks > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    task automatic wait_run();
        for (int i = 0; i < 100 && sys_reset_active !== 1'b0; i++) begin
            @(posedge sys_clk);
            #1;
        end
        if (sys_reset_active !== 1'b0) begin
            bad_count++;
            end_sim();
        end
    endtask
    initial begin
        void'($urandom(32'h68A9));
        repeat (4) @(posedge sys_clk);
        #1 rst = 1'b0;
        repeat (8) @(posedge sys_clk);
        // Model of the PHY control: strap high gives full duplex.
        pc = 16'h0100;
        i_mprc_host_model.rd(1'b0, q);
        chk(q, 16'h0000);
        i_mprc_host_model.rd(1'b1, q);
        chk(q, 16'(pc));
        chk(16'(phy_full_duplex), 16'h0001);
        for (int i = 0; i < 6; i++) begin
            d = $urandom & 16'h7FFF;
            pc = d & 16'h4900;
            i_mprc_host_model.wr(1'b1, 16'(d));
            i_mprc_host_model.rd(1'b1, q);
            chk(q, 16'(pc));
            chk(16'(tp_disable), 16'(d[14] | d[11]));
        end
        i_mprc_host_model.wr(1'b1, 16'hC800);
        i_mprc_host_model.rd(1'b1, q);
        chk(16'(q[15]), 16'h0001);
        i_mprc_host_model.phy_wait(n);
        chk(16'(n > 1 && n < 50), 16'h0001);
        i_mprc_host_model.rd(1'b1, q);
        chk(q, 16'h0100);
        i_mprc_host_model.wr(1'b0, 16'h0008);
        tx_busy = 1'b1;
        i_mprc_host_model.wr(1'b0, 16'h0088);
        chk(16'(tx_abort), 16'h0001);
        chk(16'(main_ctrl), 16'h0080);
        tx_busy = 1'b0;
        i_mprc_host_model.wr(1'b0, 16'h0000);
        chk(16'(tx_reset), 16'h0000);
        i_mprc_host_model.wr(1'b0, 16'h0004);
        rx_busy = 1'b1;
        i_mprc_host_model.wr(1'b0, 16'h0044);
        chk(16'(rx_abort), 16'h0001);
        chk(16'(main_ctrl), 16'h0040);
        rx_busy = 1'b0;
        i_mprc_host_model.wr(1'b0, 16'h000C);
        // Non-default PHY bits, so the system reset has something to undo.
        i_mprc_host_model.wr(1'b1, 16'h4800);
        chk(16'({phy_loopback, phy_power_down}), 16'h0003);
        i_mprc_host_model.cmd();
        chk(16'({sys_reset_active, tx_reset, rx_reset, phy_reset}),
            16'h000F);
        chk(16'(main_ctrl), 16'h0000);
        wait_run();
        chk(16'(phy_access_ok), 16'h0000);
        i_mprc_host_model.rd(1'b1, q);
        chk(q, 16'h0100);
        chk(16'(phy_access_ok), 16'h0001);
        i_mprc_host_model.wr(1'b0, 16'h000C);
        @(posedge sys_clk);
        #1 reset_pin_n = 1'b0;
        // A low as long as the filter time must still be ignored.
        repeat (4) @(posedge sys_clk);
        #1 reset_pin_n = 1'b1;
        seen = 1'b0;
        repeat (12) @(posedge sys_clk) seen = seen | sys_reset_active;
        chk(16'(seen), 16'h0000);
        #1 reset_pin_n = 1'b0;
        repeat (16) @(posedge sys_clk);
        #1;
        chk(16'(sys_reset_active), 16'h0001);
        chk(16'(main_ctrl), 16'h0000);
        reset_pin_n = 1'b1;
        wait_run();
        chk(16'(tx_reset | rx_reset), 16'h0000);
        chk(16'(i_mprc_host_model.misses), 16'h0000);
        end_sim();
    end
endmodule // tb_mprc_reset_ctrl

`default_nettype wire
